// File: ecs_cmd_interp.sv
// command interpreter: frame intake, checks, status and answers
`timescale 1ns/100ps
module ecs_cmd_interp
  import ecs_pkg::*;
#(
  parameter int NFIELD = 8,
  parameter logic [15:0] MEM_WORDS = 16'h0380,
  // arbitrary identification values
  parameter logic [7:0] TYPE_LABEL = 8'h5A,
  parameter logic [15:0] SERIAL_VER = 16'h1234
)(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_perr,
  input wire logic i_frame_end,
  input wire logic i_fault_valid,
  input wire logic [7:0] i_fault_code,
  input wire logic i_wdog_restart,
  output logic o_busy,
  output logic o_resp_valid,
  output logic [7:0] o_resp_cmd,
  output logic [7:0] o_resp_err,
  output logic [15:0] o_resp_data,
  output logic o_exec_valid,
  output logic [39:0] o_exec_args,
  output logic [7:0] o_status,
  output logic [7:0] o_code0,
  output logic [7:0] o_bus_addr,
  output logic [7:0] o_link_mode
);
  typedef struct packed {
    ecs_state_t st;
    logic [3:0] cnt;
    logic [7:0] cmd;
    logic [39:0] args;
    logic [7:0] xsum;
    logic perr;
    logic [7:0] code0;
    logic [7:0] status;
    logic wd_chk;
    logic resp_valid;
    logic [7:0] resp_cmd;
    logic [7:0] resp_err;
    logic [15:0] resp_data;
    logic exec_valid;
    logic [7:0] bus_addr;
    logic [7:0] link_mode;
  } ecs_regs_t;

  ecs_regs_t r;
  ecs_regs_t next_r;

  logic d_exists;
  logic d_wprot;
  logic d_fixed;
  logic d_inrange;
  logic [7:0] d_size;
  logic d_code_ok;
  logic d_fits;
  logic [15:0] d_free;
  logic dir_create;
  logic dir_newcode;
  logic [7:0] dir_field;
  logic [7:0] err;
  logic [15:0] data;
  logic exec;
  logic [4:0] ndata;

  function automatic logic [7:0] arg(input logic [39:0] a,
                                     input int k);
    return a[8*k +: 8];
  endfunction : arg

  // field number follows the access code byte on create
  assign dir_field = (r.cmd == CMD_FIELD_MAKE) ? arg(r.args, 1)
                                               : arg(r.args, 0);

  ecs_field_dir #(
    .NFIELD(NFIELD),
    .MEM_WORDS(MEM_WORDS)
  ) u_dir (
    .i_clock(i_clock),
    .i_rstn(i_rstn),
    .i_field(dir_field),
    .i_size(arg(r.args, 2)),
    .i_flags(arg(r.args, 3)),
    .i_code(arg(r.args, 1)),
    .i_new_code(arg(r.args, 2)),
    .i_create(dir_create),
    .i_newcode(dir_newcode),
    .o_exists(d_exists),
    .o_wprot(d_wprot),
    .o_fixed(d_fixed),
    .o_inrange(d_inrange),
    .o_size(d_size),
    .o_code_ok(d_code_ok),
    .o_fits(d_fits),
    .o_free(d_free)
  );

  // checks of a closed frame, in priority order
  always_comb
  begin
    err = ST_OK;
    data = 16'h0000;
    exec = 1'b0;
    dir_create = 1'b0;
    dir_newcode = 1'b0;
    ndata = 5'({1'b0, r.cnt} - 5'h02);
    if (r.st == ECS_EXEC)
    begin
      if (r.perr)
      begin
        err = ST_PARITY;
      end
      else if (r.cnt < 4'h2)
      begin
        err = ST_COUNT;
      end
      else if (r.xsum != 8'h00)
      begin
        err = ST_CSUM;
      end
      else if (ecs_arg_count(r.cmd) == 5'h10)
      begin
        err = ST_UNKNOWN;
      end
      else if (ndata != ecs_arg_count(r.cmd))
      begin
        err = ST_COUNT;
      end
      else if (ecs_needs_code0(r.cmd) && arg(r.args, 0) != r.code0)
      begin
        err = ST_CODE;
      end
      else
      begin
        unique case (r.cmd)
          CMD_ANALOG:
          begin
            if (arg(r.args, 0) != ANALOG_CHAN)
            begin
              err = ST_ARG;
            end
            else
            begin
              exec = 1'b1;
            end
          end
          CMD_DATA_READ, CMD_DATA_STORE:
          begin
            if (!d_exists)
            begin
              err = ST_NOFIELD;
            end
            else if (r.cmd == CMD_DATA_STORE && d_wprot)
            begin
              err = ST_WPROT;
            end
            else if (arg(r.args, 1) >= d_size)
            begin
              err = ST_ADDR;
            end
            else
            begin
              exec = 1'b1;
            end
          end
          CMD_FIELD_STAT:
          begin
            if (!d_exists)
            begin
              err = ST_NOFIELD;
            end
            else
            begin
              data = {6'h00, d_fixed, d_wprot, d_size};
            end
          end
          CMD_FIELD_MAKE:
          begin
            if (!d_inrange || arg(r.args, 2) == 8'h00)
            begin
              err = ST_ARG;
            end
            else if (d_exists && d_fixed)
            begin
              err = ST_FIXED;
            end
            else if (!d_fits)
            begin
              err = ST_ARG;
            end
            else
            begin
              dir_create = 1'b1;
            end
          end
          CMD_FREE_MEM:
          begin
            data = d_free;
          end
          CMD_ACC_CODE:
          begin
            if (arg(r.args, 0) == CODE0_FIELD)
            begin
              if (arg(r.args, 1) != r.code0)
              begin
                err = ST_CODE;
              end
            end
            else if (!d_exists)
            begin
              err = ST_NOFIELD;
            end
            else if (!d_code_ok)
            begin
              err = ST_CODE;
            end
            else
            begin
              dir_newcode = 1'b1;
            end
          end
          CMD_STATUS:
          begin
            data = {8'h00, r.status};
          end
          CMD_TYPE:
          begin
            data = {8'h00, TYPE_LABEL};
          end
          CMD_SERIAL:
          begin
            data = SERIAL_VER;
          end
          CMD_ADDR_SET, CMD_LINK_CFG:
          begin
            data = 16'h0000;
          end
          default:
          begin
            exec = 1'b1;
          end
        endcase
      end
    end
  end

  always_comb
  begin
    next_r = r;
    next_r.resp_valid = 1'b0;
    next_r.exec_valid = 1'b0;
    next_r.wd_chk = 1'b0;
    unique case (r.st)
      ECS_RX:
      begin
        if (i_byte_valid)
        begin
          next_r.xsum = r.xsum ^ i_byte;
          next_r.perr = r.perr | i_byte_perr;
          if (r.cnt == 4'h0)
          begin
            next_r.cmd = i_byte;
          end
          else if (r.cnt <= 4'(MAX_ARGS))
          begin
            next_r.args[8*(r.cnt-4'h1) +: 8] = i_byte;
          end
          if (r.cnt != CNT_MAX)
          begin
            next_r.cnt = r.cnt + 4'h1;
          end
        end
        if (i_frame_end)
        begin
          next_r.st = ECS_EXEC;
        end
      end
      ECS_EXEC:
      begin
        next_r.st = ECS_RX;
        next_r.cnt = 4'h0;
        next_r.xsum = 8'h00;
        next_r.perr = 1'b0;
        next_r.resp_valid = 1'b1;
        next_r.resp_cmd = r.cmd;
        next_r.resp_err = err;
        next_r.resp_data = data;
        next_r.exec_valid = exec;
        if (err == ST_OK)
        begin
          if (r.cmd == CMD_ADDR_SET)
          begin
            next_r.bus_addr = arg(r.args, 1);
          end
          if (r.cmd == CMD_LINK_CFG)
          begin
            next_r.link_mode = arg(r.args, 1);
          end
          if (r.cmd == CMD_ACC_CODE && arg(r.args, 0) == CODE0_FIELD)
          begin
            next_r.code0 = arg(r.args, 2);
          end
          if (r.cmd == CMD_STATUS)
          begin
            next_r.status = ST_OK;
          end
        end
        else
        begin
          next_r.status = err;
        end
      end
    endcase
    // sensed faults pass through unchanged; set wins over the clear
    if (i_fault_valid && i_fault_code != ST_OK)
    begin
      next_r.status = i_fault_code;
    end
    if (r.wd_chk && i_wdog_restart)
    begin
      next_r.status = ST_WDOG;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r.st <= ECS_RX;
      r.cnt <= 4'h0;
      r.cmd <= 8'h00;
      r.args <= 40'h00_0000_0000;
      r.xsum <= 8'h00;
      r.perr <= 1'b0;
      r.code0 <= CODE0_RESET;
      r.status <= ST_OK;
      r.wd_chk <= 1'b1;
      r.resp_valid <= 1'b0;
      r.resp_cmd <= 8'h00;
      r.resp_err <= 8'h00;
      r.resp_data <= 16'h0000;
      r.exec_valid <= 1'b0;
      r.bus_addr <= ADDR_RESET;
      r.link_mode <= MODE_RESET;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign o_busy = r.st == ECS_EXEC;
  assign o_resp_valid = r.resp_valid;
  assign o_resp_cmd = r.resp_cmd;
  assign o_resp_err = r.resp_err;
  assign o_resp_data = r.resp_data;
  assign o_exec_valid = r.exec_valid;
  assign o_exec_args = r.args;
  assign o_status = r.status;
  assign o_code0 = r.code0;
  assign o_bus_addr = r.bus_addr;
  assign o_link_mode = r.link_mode;
endmodule : ecs_cmd_interp

// File: ecs_pkg.sv
// constants, types and helpers for the encoder command interpreter
package ecs_pkg;
  localparam logic [7:0] CMD_POS_READ = 8'h42;
  localparam logic [7:0] CMD_POS_SET = 8'h43;
  localparam logic [7:0] CMD_ANALOG = 8'h44;
  localparam logic [7:0] CMD_CNT_READ = 8'h46;
  localparam logic [7:0] CMD_CNT_INC = 8'h47;
  localparam logic [7:0] CMD_CNT_CLR = 8'h49;
  localparam logic [7:0] CMD_DATA_READ = 8'h4A;
  localparam logic [7:0] CMD_DATA_STORE = 8'h4B;
  localparam logic [7:0] CMD_FIELD_STAT = 8'h4C;
  localparam logic [7:0] CMD_FIELD_MAKE = 8'h4D;
  localparam logic [7:0] CMD_FREE_MEM = 8'h4E;
  localparam logic [7:0] CMD_ACC_CODE = 8'h4F;
  localparam logic [7:0] CMD_STATUS = 8'h50;
  localparam logic [7:0] CMD_TYPE = 8'h52;
  localparam logic [7:0] CMD_RESET = 8'h53;
  localparam logic [7:0] CMD_ADDR_SET = 8'h55;
  localparam logic [7:0] CMD_SERIAL = 8'h56;
  localparam logic [7:0] CMD_LINK_CFG = 8'h57;
  localparam logic [7:0] ST_OK = 8'h00;
  localparam logic [7:0] ST_WDOG = 8'h07;
  localparam logic [7:0] ST_PARITY = 8'h09;
  localparam logic [7:0] ST_CSUM = 8'h0A;
  localparam logic [7:0] ST_UNKNOWN = 8'h0B;
  localparam logic [7:0] ST_COUNT = 8'h0C;
  localparam logic [7:0] ST_ARG = 8'h0D;
  localparam logic [7:0] ST_WPROT = 8'h0E;
  localparam logic [7:0] ST_CODE = 8'h0F;
  localparam logic [7:0] ST_FIXED = 8'h10;
  localparam logic [7:0] ST_ADDR = 8'h11;
  localparam logic [7:0] ST_NOFIELD = 8'h12;
  localparam logic [7:0] CODE0_RESET = 8'h55;
  localparam logic [7:0] ACC_RESET = 8'h55;
  localparam logic [7:0] ADDR_RESET = 8'h40;
  localparam logic [7:0] MODE_RESET = 8'hE4;
  localparam logic [7:0] ANALOG_CHAN = 8'h48;
  localparam logic [7:0] CODE0_FIELD = 8'hFF;
  localparam int MAX_ARGS = 5;
  localparam logic [3:0] CNT_MAX = 4'hF;
  localparam int FLAG_WPROT = 0;
  localparam int FLAG_FIXED = 1;

  typedef enum logic {ECS_RX, ECS_EXEC} ecs_state_t;

  // data bytes between command byte and checksum byte
  function automatic logic [4:0] ecs_arg_count(input logic [7:0] cmd);
    logic [4:0] r;
    r = 5'h10;
    unique case (cmd)
      CMD_POS_READ, CMD_CNT_READ, CMD_CNT_INC, CMD_FREE_MEM,
      CMD_STATUS, CMD_TYPE, CMD_RESET, CMD_SERIAL: r = 5'h00;
      CMD_ANALOG, CMD_CNT_CLR, CMD_FIELD_STAT: r = 5'h01;
      CMD_ADDR_SET, CMD_LINK_CFG: r = 5'h02;
      CMD_DATA_READ, CMD_ACC_CODE: r = 5'h03;
      CMD_DATA_STORE, CMD_FIELD_MAKE: r = 5'h04;
      CMD_POS_SET: r = 5'h05;
      default: r = 5'h10;
    endcase
    return r;
  endfunction : ecs_arg_count

  function automatic logic ecs_needs_code0(input logic [7:0] cmd);
    return cmd == CMD_POS_SET || cmd == CMD_CNT_CLR ||
           cmd == CMD_FIELD_MAKE || cmd == CMD_ADDR_SET ||
           cmd == CMD_LINK_CFG;
  endfunction : ecs_needs_code0
endpackage : ecs_pkg

// File: ecs_field_dir.sv
// data-field directory: existence, size, protection, access codes
`timescale 1ns/100ps
module ecs_field_dir
  import ecs_pkg::*;
#(
  parameter int NFIELD = 8,
  parameter logic [15:0] MEM_WORDS = 16'h0380
)(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic [7:0] i_field,
  input wire logic [7:0] i_size,
  input wire logic [7:0] i_flags,
  input wire logic [7:0] i_code,
  input wire logic [7:0] i_new_code,
  input wire logic i_create,
  input wire logic i_newcode,
  output logic o_exists,
  output logic o_wprot,
  output logic o_fixed,
  output logic o_inrange,
  output logic [7:0] o_size,
  output logic o_code_ok,
  output logic o_fits,
  output logic [15:0] o_free
);
  localparam int IW = $clog2(NFIELD);

  typedef struct packed {
    logic [NFIELD-1:0] exist;
    logic [NFIELD-1:0] wprot;
    logic [NFIELD-1:0] fixed;
    logic [NFIELD-1:0][7:0] size;
    logic [NFIELD-1:0][7:0] code;
    logic [15:0] free;
  } ecs_dir_t;

  ecs_dir_t r;
  ecs_dir_t next_r;
  logic [IW-1:0] idx;
  logic [15:0] avail;

  always_comb
  begin
    idx = i_field[IW-1:0];
    o_inrange = i_field < 8'(NFIELD);
    o_exists = o_inrange && r.exist[idx];
    o_wprot = r.wprot[idx];
    o_fixed = r.fixed[idx];
    o_size = r.size[idx];
    o_code_ok = r.code[idx] == i_code;
    o_free = r.free;
    // space held by the field today is given back on resize
    avail = r.free + (o_exists ? {8'h00, r.size[idx]} : 16'h0000);
    o_fits = avail >= {8'h00, i_size};
    next_r = r;
    if (i_create)
    begin
      next_r.exist[idx] = 1'b1;
      next_r.size[idx] = i_size;
      next_r.wprot[idx] = i_flags[FLAG_WPROT];
      next_r.fixed[idx] = i_flags[FLAG_FIXED];
      next_r.free = avail - {8'h00, i_size};
    end
    if (i_newcode)
    begin
      next_r.code[idx] = i_new_code;
    end
  end

  always_ff @(posedge i_clock or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r.exist <= '0;
      r.wprot <= '0;
      r.fixed <= '0;
      r.size <= '0;
      r.code <= {NFIELD{ACC_RESET}};
      r.free <= MEM_WORDS;
    end
    else
    begin
      r <= next_r;
    end
  end
endmodule : ecs_field_dir

// File: ecs_cmd_interp_chk.sv
// port assertions for the encoder command interpreter
`timescale 1ns/100ps
module ecs_cmd_interp_chk
  import ecs_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rstn,
  input wire logic i_frame_end,
  input wire logic i_fault_valid,
  input wire logic i_wdog_restart,
  input wire logic o_busy,
  input wire logic o_resp_valid,
  input wire logic [7:0] o_resp_cmd,
  input wire logic [7:0] o_resp_err,
  input wire logic o_exec_valid,
  input wire logic [7:0] o_status,
  input wire logic [7:0] o_code0,
  input wire logic [7:0] o_bus_addr
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);

  chk_code0_reset:
  assert property (!$past(i_rstn) |-> o_code0 == 8'h55)
    else $error("code0 not 55h after reset");
  chk_status_clean:
  assert property (!$past(i_rstn) && !i_wdog_restart && !i_fault_valid
    |=> o_status == ST_OK)
    else $error("status not clear after reset");
  chk_wdog_status:
  assert property (!$past(i_rstn) && i_wdog_restart
    |-> ##[1:2] o_status == ST_WDOG)
    else $error("watchdog restart not reported");
  chk_answer_time:
  assert property (i_frame_end && !o_busy
    |=> o_busy ##1 (o_resp_valid && !o_busy))
    else $error("answer not two cycles after frame end");
  chk_err_latch:
  assert property (o_resp_valid && o_resp_err != ST_OK
    && !$past(i_fault_valid) |-> o_status == o_resp_err)
    else $error("error code not latched");
  chk_status_read:
  assert property (o_resp_valid && o_resp_cmd == CMD_STATUS
    && o_resp_err == ST_OK && !$past(i_fault_valid) |-> o_status == ST_OK)
    else $error("status not cleared by read");
  chk_exec_ok:
  assert property (o_exec_valid |-> o_resp_valid && o_resp_err == ST_OK)
    else $error("execute without clean answer");
  chk_known_only:
  assert property (o_resp_valid && o_resp_err == ST_OK |-> o_resp_cmd
    inside {[8'h42:8'h44], 8'h46, 8'h47, [8'h49:8'h50], 8'h52, 8'h53,
    [8'h55:8'h57]})
    else $error("unknown command accepted");
  chk_code0_guard:
  assert property ($changed(o_code0) |-> o_resp_valid
    && o_resp_cmd == CMD_ACC_CODE && o_resp_err == ST_OK)
    else $error("code0 changed without accepted command");
  chk_addr_guard:
  assert property ($changed(o_bus_addr) |-> o_resp_valid
    && o_resp_cmd == CMD_ADDR_SET && o_resp_err == ST_OK)
    else $error("address changed without accepted command");
endmodule : ecs_cmd_interp_chk

bind ecs_cmd_interp ecs_cmd_interp_chk chk_u (
  .i_clock, .i_rstn, .i_frame_end, .i_fault_valid, .i_wdog_restart,
  .o_busy, .o_resp_valid, .o_resp_cmd, .o_resp_err, .o_exec_valid,
  .o_status, .o_code0, .o_bus_addr
);

// File: ecs_drive_model.sv
// drive controller model sending command frames
`timescale 1ns/100ps
module ecs_drive_model (
  input wire logic i_clock,
  output logic o_byte_valid,
  output logic [7:0] o_byte,
  output logic o_byte_perr,
  output logic o_frame_end
);
  initial
  begin
    o_byte_valid = 1'b0;
    o_byte = 8'h00;
    o_byte_perr = 1'b0;
    o_frame_end = 1'b0;
  end

  // cmd, n data bytes (byte k at bits 8k), then checksum
  task automatic send(input logic [7:0] cmd, input logic [39:0] a,
                      input int n, input bit p, input bit bad);
    logic [7:0] s;
    logic [7:0] b;
    s = 8'h00;
    for (int k = 0; k <= n + 1; k++)
    begin
      if (k == 0)
        b = cmd;
      else if (k <= n)
        b = a[8*(k-1)+:8];
      else
        b = s ^ {7'h00, bad};
      s = s ^ b;
      @(posedge i_clock);
      o_byte_valid <= 1'b1;
      o_byte <= b;
      o_byte_perr <= p && k == 1;
    end
    @(posedge i_clock);
    o_byte_valid <= 1'b0;
    o_byte <= ~b;
    o_byte_perr <= 1'b0;
    o_frame_end <= 1'b1;
    @(posedge i_clock);
    o_frame_end <= 1'b0;
  endtask : send
endmodule : ecs_drive_model

// File: tb_encoder_command_status_set.sv
// self-checking bench for the encoder command interpreter
`timescale 1ns/100ps
module tb_encoder_command_status_set
  import ecs_pkg::*;
;
  logic i_clock;
  logic i_rstn;
  logic i_byte_valid;
  logic [7:0] i_byte;
  logic i_byte_perr;
  logic i_frame_end;
  logic i_fault_valid;
  logic [7:0] i_fault_code;
  logic i_wdog_restart;
  logic o_busy;
  logic o_resp_valid;
  logic [7:0] o_resp_cmd;
  logic [7:0] o_resp_err;
  logic [15:0] o_resp_data;
  logic o_exec_valid;
  logic [39:0] o_exec_args;
  logic [7:0] o_status;
  logic [7:0] o_code0;
  logic [7:0] o_bus_addr;
  logic [7:0] o_link_mode;
  logic [15:0] r_data;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;

  always #4 i_clock = ~i_clock;

  // type label and serial values are arbitrary
  ecs_cmd_interp #(.TYPE_LABEL(8'h3C), .SERIAL_VER(16'hC35A)) dut_u (
    .i_clock, .i_rstn, .i_byte_valid, .i_byte, .i_byte_perr,
    .i_frame_end, .i_fault_valid, .i_fault_code, .i_wdog_restart,
    .o_busy, .o_resp_valid, .o_resp_cmd, .o_resp_err, .o_resp_data,
    .o_exec_valid, .o_exec_args, .o_status, .o_code0, .o_bus_addr,
    .o_link_mode
  );
  ecs_drive_model drv_u (
    .i_clock, .o_byte_valid(i_byte_valid), .o_byte(i_byte),
    .o_byte_perr(i_byte_perr), .o_frame_end(i_frame_end)
  );

  task automatic chk(input string w, input logic [15:0] e,
                     input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, e, g);
    end
  endtask : chk

  task automatic run(input logic [7:0] c, input logic [39:0] a,
                     input int n, input logic [7:0] e,
                     input bit p = 1'b0, input bit bad = 1'b0);
    int w;
    drv_u.send(c, a, n, p, bad);
    w = 0;
    while (o_resp_valid !== 1'b1 && w < 8)
    begin
      @(posedge i_clock);
      #1;
      w++;
    end
    chk("answer", {7'h00, 1'b1, e}, {7'h00, o_resp_valid, o_resp_err});
    chk("cmd", {8'h00, c}, {8'h00, o_resp_cmd});
    r_data = o_resp_data;
  endtask : run

  task automatic t_reset(input bit wd);
    i_rstn <= 1'b0;
    i_wdog_restart <= wd;
    repeat (3) @(posedge i_clock);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clock);
    i_wdog_restart <= 1'b0;
    #1;
    chk("status", wd ? 16'h0007 : 16'h0000,
        16'(o_status));
    chk("code0", 16'h0055, 16'(o_code0));
    chk("addr", 16'h40E4, {o_bus_addr, o_link_mode});
    $display("reset test done");
  endtask : t_reset

  task automatic t_cmds;
    logic [7:0] z [5] = '{8'h42, 8'h46, 8'h47, 8'h50, 8'h53};
    logic [7:0] u [4] = '{8'h45, 8'h48, 8'h51, 8'h54};
    foreach (z[i]) run(z[i], 40'h0, 0, 8'h00);
    foreach (u[i]) run(u[i], 40'h0, 0, 8'h0B);
    run(8'h4E, 40'h0, 0, 8'h00);
    chk("free", 16'h0380, r_data);
    chk("exec", 16'h0000, 16'(o_exec_valid));
    run(8'h52, 40'h0, 0, 8'h00);
    chk("type", 16'h003C, r_data);
    run(8'h56, 40'h0, 0, 8'h00);
    chk("serial", 16'hC35A, r_data);
    run(8'h43, 40'h0403020155, 5, 8'h00);
    chk("args", 16'h0155, o_exec_args[15:0]);
    chk("exec", 16'h0001, 16'(o_exec_valid));
    run(8'h44, 40'h48, 1, 8'h00);
    run(8'h44, 40'h47, 1, 8'h0D);
    run(8'h49, 40'h55, 1, 8'h00);
    run(8'h49, 40'h54, 1, 8'h0F);
    run(8'h42, 40'h00, 1, 8'h0C);
    run(8'h4B, 40'h0, 3, 8'h0C);
    $display("command test done");
  endtask : t_cmds

  task automatic t_errs;
    run(8'h42, 40'h0, 0, 8'h09, 1'b1);
    chk("status", 16'h0009, 16'(o_status));
    run(8'h42, 40'h0, 0, 8'h0A, 1'b0, 1'b1);
    run(8'h50, 40'h0, 0, 8'h00);
    chk("read", 16'h000A, r_data);
    chk("status", 16'h0000, 16'(o_status));
    $display("error test done");
  endtask : t_errs

  task automatic t_prot;
    run(8'h55, 40'h4155, 2, 8'h00);
    run(8'h57, 40'hE555, 2, 8'h00);
    run(8'h55, 40'h4254, 2, 8'h0F);
    chk("addr", 16'h41E5, {o_bus_addr, o_link_mode});
    run(8'h4F, 40'hA555FF, 3, 8'h00);
    chk("code0", 16'h00A5, 16'(o_code0));
    run(8'h57, 40'hE655, 2, 8'h0F);
    $display("protection test done");
  endtask : t_prot

  task automatic t_field;
    run(8'h4A, 40'h0, 3, 8'h12);
    run(8'h4D, 40'h0001040155, 4, 8'h00);
    run(8'h4E, 40'h0, 0, 8'h00);
    chk("free", 16'h037C, r_data);
    run(8'h4C, 40'h01, 1, 8'h00);
    chk("field", 16'h0104, r_data);
    run(8'h4B, 40'h0034120001, 4, 8'h0E);
    run(8'h4D, 40'h0002020255, 4, 8'h00);
    run(8'h4D, 40'h0002030255, 4, 8'h10);
    run(8'h4A, 40'h0202, 3, 8'h11);
    run(8'h4A, 40'h0102, 3, 8'h00);
    run(8'h4F, 40'h770001, 3, 8'h0F);
    run(8'h4F, 40'h775501, 3, 8'h00);
    run(8'h4F, 40'h775505, 3, 8'h12);
    run(8'h4C, 40'h05, 1, 8'h12);
    run(8'h4D, 40'h0000080155, 4, 8'h00);
    run(8'h4E, 40'h0, 0, 8'h00);
    chk("free", 16'h0376, r_data);
    run(8'h4D, 40'h0000010955, 4, 8'h0D);
    $display("field test done");
  endtask : t_field

  task automatic t_fault;
    logic [7:0] f [14] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
      8'h1D, 8'h1E, 8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h00};
    logic [7:0] e;
    foreach (f[i])
    begin
      @(posedge i_clock);
      i_fault_valid <= 1'b1;
      i_fault_code <= f[i];
      @(posedge i_clock);
      i_fault_valid <= 1'b0;
      @(posedge i_clock);
      #1;
      // a 00h code is ignored, so the previous fault stays
      e = (i == 13) ? 8'h23 : f[i];
      chk("fault", 16'(e), 16'(o_status));
    end
    $display("fault test done");
  endtask : t_fault

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  always @(posedge i_clock)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      fail_count++;
      finish_test();
    end
  end

  initial
  begin
    i_clock = 1'b0;
    i_rstn = 1'b0;
    i_fault_valid = 1'b0;
    i_fault_code = 8'h00;
    i_wdog_restart = 1'b0;
    t_reset(1'b0);
    t_cmds();
    t_errs();
    t_prot();
    t_reset(1'b0);
    t_field();
    t_fault();
    t_reset(1'b1);
    finish_test();
  end
endmodule : tb_encoder_command_status_set
